/* File: rtl/tefc_pkg.sv */
package tefc_pkg;
  // Register byte offsets
  localparam logic [11:0] TEFC_OFF_CFG = 12'h0F0;
  localparam logic [11:0] TEFC_OFF_CTRL = 12'h0F4;
  localparam logic [11:0] TEFC_OFF_STAT = 12'h0F8;
  localparam logic [11:0] TEFC_OFF_IRQ_ST = 12'h0FC;
  localparam logic [11:0] TEFC_OFF_IRQ_CLR = 12'h100;
  localparam logic [11:0] TEFC_OFF_IRQ_EN = 12'h104;
  // Config field positions
  localparam int TEFC_WM_LSB = 24;
  localparam int TEFC_SZ_LSB = 16;
  localparam int TEFC_SA_LSB = 2;
  localparam int TEFC_SA_W = 14;
  localparam int TEFC_LVL_W = 6;
  // Control bit positions
  localparam int TEFC_CTRL_HOLD = 0;
  localparam int TEFC_CTRL_PERMIT = 1;
  // Fill count, watermark and size limits
  localparam logic [5:0] TEFC_MAX_ELEM = 6'h20;
  localparam logic [5:0] TEFC_LVL_ZERO = 6'h00;
  localparam logic [5:0] TEFC_LVL_ONE = 6'h01;
  localparam logic [31:0] TEFC_CFG_RST = 32'h00000000;
  localparam logic [31:0] TEFC_CFG_MASK = 32'h3F3FFFFC;
  // Decoded configuration carried to the FIFO logic
  typedef struct packed {
    logic [5:0] watermark;
    logic [5:0] size;
    logic [13:0] start_word;
  } tefc_cfg_t;
endpackage

/* File: rtl/tefc_top.sv */
`timescale 1ns/1ns
module tefc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic evt_push,
  input wire logic evt_pop,
  output logic [5:0] put_index,
  output logic [5:0] get_index,
  output logic [5:0] fill_level,
  output logic [13:0] start_word,
  output logic irq
);
  import tefc_pkg::*;

  // All checks below run on the bus clock, off during reset
  default clocking tefc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [31:0] cfg_q;
  logic [1:0] ctrl_q;
  logic flag_q;
  logic flag_en_q;
  logic [5:0] put_q, get_q, fill_q;
  logic [5:0] size_eff, wm;
  logic wr, rd, wm_hit, clr_flag, fifo_on, do_push, do_pop;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic cfg_wr;
  tefc_cfg_t cfg;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // Field decode with size clamp
  always_comb begin
    cfg.watermark = cfg_q[TEFC_WM_LSB +: TEFC_LVL_W];
    cfg.size = cfg_q[TEFC_SZ_LSB +: TEFC_LVL_W];
    cfg.start_word = cfg_q[TEFC_SA_LSB +: TEFC_SA_W];
    size_eff = (cfg.size > TEFC_MAX_ELEM) ? TEFC_MAX_ELEM : cfg.size;
    wm = cfg.watermark;
  end

  assign fifo_on = (size_eff != TEFC_LVL_ZERO);
  assign do_push = evt_push && fifo_on && (fill_q < size_eff);
  assign do_pop = evt_pop && fifo_on && (fill_q != TEFC_LVL_ZERO);
  // Watermark valid only in 1..32
  assign wm_hit = fifo_on && (wm != TEFC_LVL_ZERO) && (wm <= TEFC_MAX_ELEM)
    && (fill_q >= wm);
  assign clr_flag = wr && (paddr == TEFC_OFF_IRQ_CLR) && pwdata[0];
  // Config write lands only with both control bits set
  assign cfg_wr = wr && (paddr == TEFC_OFF_CFG) && ctrl_q[TEFC_CTRL_HOLD]
    && ctrl_q[TEFC_CTRL_PERMIT];

  // Config register, locked unless both control bits set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= TEFC_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= pwdata & TEFC_CFG_MASK;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 2'h0;
    end else if (wr && paddr == TEFC_OFF_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // Put/get indices wrap at effective size
  // Cleared when off or reconfigured, so a shrink never strands an index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      put_q <= TEFC_LVL_ZERO;
      get_q <= TEFC_LVL_ZERO;
      fill_q <= TEFC_LVL_ZERO;
    end else if (!fifo_on || cfg_wr) begin
      put_q <= TEFC_LVL_ZERO;
      get_q <= TEFC_LVL_ZERO;
      fill_q <= TEFC_LVL_ZERO;
    end else begin
      if (do_push) begin
        put_q <= (put_q >= size_eff - TEFC_LVL_ONE) ? TEFC_LVL_ZERO
                 : put_q + TEFC_LVL_ONE;
      end
      if (do_pop) begin
        get_q <= (get_q >= size_eff - TEFC_LVL_ONE) ? TEFC_LVL_ZERO
                 : get_q + TEFC_LVL_ONE;
      end
      if (do_push && !do_pop) begin
        fill_q <= fill_q + TEFC_LVL_ONE;
      end else if (do_pop && !do_push) begin
        fill_q <= fill_q - TEFC_LVL_ONE;
      end
    end
  end

  // Sticky watermark flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (wm_hit) begin
      flag_q <= 1'b1;
    end else if (clr_flag) begin
      flag_q <= 1'b0;
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_en_q <= 1'b0;
    end else if (wr && paddr == TEFC_OFF_IRQ_EN) begin
      flag_en_q <= pwdata[0];
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h00000000;
    addr_ok = 1'b1;
    unique case (paddr)
      TEFC_OFF_CFG: rdata_d = cfg_q;
      TEFC_OFF_CTRL: rdata_d = {30'h00000000, ctrl_q};
      TEFC_OFF_STAT: rdata_d = {8'h00, 2'h0, get_q, 2'h0, put_q,
                                2'h0, fill_q};
      TEFC_OFF_IRQ_ST: rdata_d = {31'h00000000, flag_q};
      TEFC_OFF_IRQ_CLR: rdata_d = 32'h00000000;
      TEFC_OFF_IRQ_EN: rdata_d = {31'h00000000, flag_en_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: no wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd) begin
        prdata <= rdata_d;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      put_index <= TEFC_LVL_ZERO;
      get_index <= TEFC_LVL_ZERO;
      fill_level <= TEFC_LVL_ZERO;
      start_word <= 14'h0000;
      irq <= 1'b0;
    end else begin
      put_index <= put_q;
      get_index <= get_q;
      fill_level <= fill_q;
      start_word <= cfg.start_word;
      irq <= flag_q && flag_en_q;
    end
  end

  // Config lock and write path
  a_cfg_locked: assert property (
    !(ctrl_q[TEFC_CTRL_HOLD] && ctrl_q[TEFC_CTRL_PERMIT]) |=> $stable(cfg_q))
    else $error("config changed while locked");
  a_cfg_taken: assert property (
    cfg_wr |=> cfg_q == ($past(pwdata) & TEFC_CFG_MASK))
    else $error("unlocked config write lost");
  a_addr_low: assert property (
    cfg_q[1:0] == 2'h0)
    else $error("address low bits set");
  // Watermark flag set, hold and disable
  a_wm_flag: assert property (
    wm_hit |=> flag_q)
    else $error("watermark flag missed");
  a_wm_off: assert property (
    (wm > TEFC_MAX_ELEM || wm == TEFC_LVL_ZERO) && !flag_q |=> !flag_q)
    else $error("disabled watermark set flag");
  a_flag_sticky: assert property (
    flag_q && !clr_flag |=> flag_q)
    else $error("flag dropped without clear");
  a_irq_path: assert property (
    wm_hit ##1 flag_en_q |=> irq)
    else $error("irq missing");
  a_irq_level: assert property (
    irq == ($past(flag_q) && $past(flag_en_q)))
    else $error("irq not flag and enable");
  // FIFO size, index range and wrap
  a_size_zero: assert property (
    cfg.size == TEFC_LVL_ZERO |=> fill_q == TEFC_LVL_ZERO)
    else $error("disabled fifo holds data");
  a_size_clamp: assert property (
    fill_q <= TEFC_MAX_ELEM)
    else $error("fill above 32");
  a_put_wrap: assert property (
    do_push && put_q == size_eff - TEFC_LVL_ONE |=> put_q == TEFC_LVL_ZERO)
    else $error("put index did not wrap");
  a_get_wrap: assert property (
    do_pop && get_q == size_eff - TEFC_LVL_ONE |=> get_q == TEFC_LVL_ZERO)
    else $error("get index did not wrap");
  a_idx_range: assert property (
    fifo_on |-> put_q < size_eff && get_q < size_eff)
    else $error("index out of range");
  // Main scenarios
  c_cfg_write: cover property (cfg_wr);
  c_wrap: cover property (do_push && put_q != TEFC_LVL_ZERO
    ##1 put_q == TEFC_LVL_ZERO);
  c_full: cover property (fifo_on && fill_q == size_eff && evt_push);
  c_flag_set: cover property ($rose(flag_q));
  c_irq: cover property (irq);
endmodule // tefc_top

/* File: testbench/tefc_top_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tefc_top_tb;
  import tefc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic evt_push = 0, evt_pop = 0, pready, pslverr, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [5:0] put_index, get_index, fill_level, wm;
  logic [13:0] start_word;
  int bad_count = 0, n_tests = 0;
  // Free-running bus clock
  always #5 pclk = ~pclk;
  tefc_top tefc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_push(evt_push), .evt_pop(evt_pop), .put_index(put_index),
    .get_index(get_index), .fill_level(fill_level),
    .start_word(start_word), .irq(irq));
  // Verdict and end of run
  task automatic test_done;
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Expected fill: size zero off, above 32 acts as 32, push refused full
  function automatic logic [5:0] exp_fill(input logic [5:0] sz,
                                          input int n);
    int lim;
    lim = (sz > TEFC_MAX_ELEM) ? int'(TEFC_MAX_ELEM) : int'(sz);
    return (n < lim) ? 6'(n) : 6'(lim);
  endfunction
  // Expected readback: unused bits and address bits 1:0 read zero
  function automatic logic [31:0] exp_cfg(input logic [31:0] v);
    return v & TEFC_CFG_MASK;
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Unlocked configuration write
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, TEFC_OFF_CTRL, 32'h3);
    apb(1'b1, TEFC_OFF_CFG, v);
  endtask
  // Push or pop for n cycles, then let outputs settle
  task automatic ev(input logic p, input int n);
    evt_push <= p; evt_pop <= ~p;
    repeat (n) @(posedge pclk);
    evt_push <= 1'b0; evt_pop <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Hang guard
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  // Main sequence
  initial begin
    d = $urandom(32'hC4D5DC8E);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, TEFC_OFF_CFG, 32'h0);
    `CHK("cfg_reset", TEFC_CFG_RST, rd)
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      cfg(d);
      apb(1'b0, TEFC_OFF_CFG, 32'h0);
      `CHK("cfg_write", exp_cfg(d), rd)
      `CHK("start_word", d[15:2], start_word)
      apb(1'b1, TEFC_OFF_CTRL, 32'(i % 3));
      apb(1'b1, TEFC_OFF_CFG, ~d);
      apb(1'b0, TEFC_OFF_CFG, 32'h0);
      `CHK("cfg_locked", exp_cfg(d), rd)
    end
    apb(1'b0, 12'h200, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    // Size three: overfill with put index wrap, then one pop
    cfg(32'h0); cfg(32'h00030000); ev(1'b1, 5);
    `CHK("fill_full", exp_fill(6'h03, 5), fill_level)
    `CHK("put_wrap", 6'h00, put_index)
    ev(1'b0, 1);
    `CHK("get_idx", 6'h01, get_index)
    apb(1'b0, TEFC_OFF_STAT, 32'h0);
    `CHK("stat_fill", exp_fill(6'h03, 5) - 6'h01, rd[5:0])
    `CHK("stat_get", 6'h01, rd[21:16])
    // Size above 32 clamps
    cfg(32'h0); cfg(32'h00280000); ev(1'b1, 33);
    `CHK("fill_clamp", exp_fill(6'h28, 33), fill_level)
    `CHK("put_clamp", 6'h00, put_index)
    // Size zero keeps the FIFO off
    cfg(32'h0); ev(1'b1, 2);
    `CHK("fill_off", exp_fill(6'h00, 2), fill_level)
    // Watermark two, masked then enabled
    apb(1'b1, TEFC_OFF_IRQ_CLR, 32'h1); cfg(32'h02040000); ev(1'b1, 1);
    apb(1'b0, TEFC_OFF_IRQ_ST, 32'h0);
    `CHK("flag_below", 1'b0, rd[0])
    ev(1'b1, 1);
    apb(1'b0, TEFC_OFF_IRQ_ST, 32'h0);
    `CHK("flag_hit", 1'b1, rd[0])
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, TEFC_OFF_IRQ_EN, 32'h1); repeat (3) @(posedge pclk);
    `CHK("irq_on", 1'b1, irq)
    cfg(32'h0); apb(1'b1, TEFC_OFF_IRQ_CLR, 32'h1); repeat (3) @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    // Watermark 0 and 33 stay silent at a full FIFO
    for (int k = 0; k < 2; k++) begin
      wm = k ? 6'h21 : 6'h00;
      cfg(32'h0); apb(1'b1, TEFC_OFF_IRQ_CLR, 32'h1);
      cfg({2'b00, wm, 8'h20, 16'h0000}); ev(1'b1, 32);
      `CHK("irq_wm_off", 1'b0, irq)
    end
    test_done;
  end
endmodule // tefc_top_tb
